/* hw/acms_defs.vh */
`ifndef ACMS_DEFS_VH
`define ACMS_DEFS_VH
// ==========================================================
// Frame layout
`define ACMS_FRAME_BITS      6'd32
`define ACMS_HDR_BITS        6'd12
`define ACMS_HDR_PATTERN     12'h001
`define ACMS_ADDR_W          4
`define ACMS_DATA_W          16
// ==========================================================
// Register addresses
`define ACMS_ADDR_CONFIG     4'h1
`define ACMS_ADDR_I_OFFSET   4'h2
`define ACMS_ADDR_I_FSCALE   4'h3
`define ACMS_ADDR_Q_OFFSET   4'hA
`define ACMS_ADDR_Q_FSCALE   4'hB
`define ACMS_ADDR_DE_ENABLE  4'hD
`define ACMS_ADDR_DE_COARSE  4'hE
`define ACMS_ADDR_DE_FINE    4'hF
// ==========================================================
// Power-on values (16'hB2FF config, offset 0 mV, 700 mV scale)
`define ACMS_RST_CONFIG      16'hB2FF
`define ACMS_RST_OFFSET      16'h007F
`define ACMS_RST_FSCALE      16'h807F
`define ACMS_RST_DE_ENABLE   16'h3FFF
`define ACMS_RST_DE_COARSE   16'h0000
`define ACMS_RST_DE_FINE     16'h0000
// ==========================================================
// Field positions
`define ACMS_CFG_PHASE_BIT   11
`define ACMS_CFG_NDDR_BIT    10
`define ACMS_CFG_SWING_BIT   9
`define ACMS_CFG_EDGE_BIT    8
`define ACMS_DE_ON_BIT       15
`define ACMS_DE_AUTO_BIT     14
`define ACMS_DE_QSEL_BIT     13
`endif

/* hw/acms_serial_config.v */
// Overview of operation
// - Control mode comes from a static mode pin, never toggled in use.
// - Serial port is heard only in register-controlled mode.
// - Data sampled on each serial clock rising edge while select low.
// - Each write is one 32-bit frame, most significant bit first.
// - First 12 bits are the fixed header: eleven zeros then a one.
// - Then 4 address bits and 16 data bits, written to that register.
// - A new frame may start at the 33rd edge without select release.
// - Eight write-only registers, no read-back path.
// - Power-on defaults: DDR, 0 deg, normal swing, short delay, 700 mV.
// - DDR phase fixed 0 deg in pin mode, else config phase bit.
// - Full scale: pin pick in pin mode, per-channel registers else.
// - Offset adjust only in register mode, per channel registers.
// - Dual-edge input is in-phase only in pin mode, selectable else.
// - Dual-edge phase auto in pin mode; bit 14 of enable reg else.
// - Calibration delay from pin in pin mode, short in register mode.
// - Rate and edge from shared pin, or config bits in register mode.
// - Swing from pin in pin mode, config swing bit in register mode.
// - Address shifted MSB first after header; config at address 1.
// - Register contents have no effect while in pin mode.
// - Shared pin floating selects DDR; high/low selects SDR edge.
`timescale 1ns/100ps
`include "acms_defs.vh"

module acms_serial_config (
	input  wire        i_clk_sys,
	input  wire        i_rstn,
	input  wire        i_control_mode_select,
	input  wire        i_serial_clock,
	input  wire        i_serial_select_n,
	input  wire        i_serial_data_in,
	input  wire        i_clk_pin_float,
	input  wire        i_clk_pin_level,
	input  wire        i_swing_pin,
	input  wire        i_cal_delay_pin,
	input  wire        i_fscale_pin,
	input  wire        i_des_pin,
	output reg         o_ddr_enable,
	output reg         o_sdr_rising_edge,
	output reg         o_ddr_phase_90,
	output reg         o_output_swing_high,
	output reg         o_cal_delay_long,
	output reg         o_fscale_pin_high,
	output reg         o_fscale_from_regs,
	output reg  [15:0] o_i_offset,
	output reg  [15:0] o_i_fscale,
	output reg  [15:0] o_q_offset,
	output reg  [15:0] o_q_fscale,
	output reg         o_offset_enable,
	output reg         o_des_enable,
	output reg         o_des_q_select,
	output reg         o_des_auto_phase,
	output reg  [15:0] o_des_coarse,
	output reg  [15:0] o_des_fine,
	output reg         o_write_strobe
);

	// ==========================================================
	// Input synchronisers
	// Every pin is foreign to i_clk_sys; two flops before use.
	reg  [10:0] sync1_reg;
	reg  [10:0] sync2_reg;
	reg         sclk_prev_reg;
	wire [10:0] pins_in;

	assign pins_in = {i_control_mode_select, i_serial_clock,
		i_serial_select_n, i_serial_data_in, i_clk_pin_float,
		i_clk_pin_level, i_swing_pin, i_cal_delay_pin,
		i_fscale_pin, i_des_pin, 1'b0};

	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			sync1_reg     <= 11'h7_FF;
			sync2_reg     <= 11'h7_FF;
			sclk_prev_reg <= 1'b1;
		end else begin
			sync1_reg     <= pins_in;
			sync2_reg     <= sync1_reg;
			sclk_prev_reg <= sync2_reg[9];
		end
	end

	wire ext_mode   = sync2_reg[10];  // High: register-controlled
	wire sclk_s     = sync2_reg[9];
	wire sel_n_s    = sync2_reg[8];
	wire serial_data_in_s    = sync2_reg[7];
	wire pin_float  = sync2_reg[6];
	wire pin_level  = sync2_reg[5];
	wire swing_pin  = sync2_reg[4];
	wire cdelay_pin = sync2_reg[3];
	wire fs_pin     = sync2_reg[2];
	wire des_pin    = sync2_reg[1];

	// Sample point; the synchroniser delay is far below the 48 ns period
	wire sclk_rise = sclk_s & ~sclk_prev_reg;

	// ==========================================================
	// Frame shifter
	reg  [31:0] shift_reg;
	reg  [31:0] shift_next;
	reg  [5:0]  count_reg;
	reg  [5:0]  count_next;
	reg         frame_done;
	wire        port_open;

	assign port_open = ext_mode & ~sel_n_s;

	always @* begin
		shift_next = shift_reg;
		count_next = count_reg;
		frame_done = 1'b0;
		if (!port_open) begin
			// Partial frame dropped; next select starts at a header
			count_next = 6'h00;
		end else if (sclk_rise) begin
			shift_next = {shift_reg[30:0], serial_data_in_s};
			if (count_reg == `ACMS_FRAME_BITS - 6'd1) begin
				// Back-to-back frames: edge 33 begins the next
				count_next = 6'h00;
				frame_done = 1'b1;
			end else begin
				count_next = count_reg + 6'd1;
			end
		end
	end

	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			shift_reg <= 32'h0000_0000;
			count_reg <= 6'h00;
		end else begin
			shift_reg <= shift_next;
			count_reg <= count_next;
		end
	end

	// Fields of the frame just completed
	wire [11:0] hdr   = shift_next[31:20];
	wire [3:0]  waddr = shift_next[19:16];
	wire [15:0] wdata = shift_next[15:0];
	wire        hdr_ok = (hdr == `ACMS_HDR_PATTERN);

	// ==========================================================
	// Write-only register file, no read path exists
	reg [15:0] config_reg;
	reg [15:0] i_off_reg;
	reg [15:0] i_fs_reg;
	reg [15:0] q_off_reg;
	reg [15:0] q_fs_reg;
	reg [15:0] de_en_reg;
	reg [15:0] de_coarse_reg;
	reg [15:0] de_fine_reg;
	reg        wr_hit;

	// Reserved addresses fall through every branch
	always @* begin
		wr_hit = 1'b0;
		if (waddr == `ACMS_ADDR_CONFIG)
			wr_hit = 1'b1;
		else if (waddr == `ACMS_ADDR_I_OFFSET)
			wr_hit = 1'b1;
		else if (waddr == `ACMS_ADDR_I_FSCALE)
			wr_hit = 1'b1;
		else if (waddr == `ACMS_ADDR_Q_OFFSET)
			wr_hit = 1'b1;
		else if (waddr == `ACMS_ADDR_Q_FSCALE)
			wr_hit = 1'b1;
		else if (waddr >= `ACMS_ADDR_DE_ENABLE)
			wr_hit = 1'b1;
	end

	wire wr_go = frame_done & hdr_ok & wr_hit;

	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			config_reg    <= `ACMS_RST_CONFIG;
			i_off_reg     <= `ACMS_RST_OFFSET;
			i_fs_reg      <= `ACMS_RST_FSCALE;
			q_off_reg     <= `ACMS_RST_OFFSET;
			q_fs_reg      <= `ACMS_RST_FSCALE;
			de_en_reg     <= `ACMS_RST_DE_ENABLE;
			de_coarse_reg <= `ACMS_RST_DE_COARSE;
			de_fine_reg   <= `ACMS_RST_DE_FINE;
			o_write_strobe <= 1'b0;
		end else begin
			o_write_strobe <= wr_go;
			if (wr_go) begin
				if (waddr == `ACMS_ADDR_CONFIG)
					config_reg <= wdata;
				else if (waddr == `ACMS_ADDR_I_OFFSET)
					i_off_reg <= wdata;
				else if (waddr == `ACMS_ADDR_I_FSCALE)
					i_fs_reg <= wdata;
				else if (waddr == `ACMS_ADDR_Q_OFFSET)
					q_off_reg <= wdata;
				else if (waddr == `ACMS_ADDR_Q_FSCALE)
					q_fs_reg <= wdata;
				else if (waddr == `ACMS_ADDR_DE_ENABLE)
					de_en_reg <= wdata;
				else if (waddr == `ACMS_ADDR_DE_COARSE)
					de_coarse_reg <= wdata;
				else
					de_fine_reg <= wdata;
			end
		end
	end

	// ==========================================================
	// Feature selection by control mode
	// Mode pin is assumed static; a change takes effect within 3 cycles
	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_ddr_enable        <= 1'b1;
			o_sdr_rising_edge   <= 1'b0;
			o_ddr_phase_90      <= 1'b0;
			o_output_swing_high <= 1'b1;
			o_cal_delay_long    <= 1'b0;
			o_fscale_pin_high   <= 1'b0;
			o_fscale_from_regs  <= 1'b0;
			o_i_offset          <= 16'h0000;
			o_i_fscale          <= 16'h0000;
			o_q_offset          <= 16'h0000;
			o_q_fscale          <= 16'h0000;
			o_offset_enable     <= 1'b0;
			o_des_enable        <= 1'b0;
			o_des_q_select      <= 1'b0;
			o_des_auto_phase    <= 1'b1;
			o_des_coarse        <= 16'h0000;
			o_des_fine          <= 16'h0000;
		end else if (ext_mode) begin
			o_ddr_enable        <= ~config_reg[`ACMS_CFG_NDDR_BIT];
			o_sdr_rising_edge   <= config_reg[`ACMS_CFG_EDGE_BIT];
			o_ddr_phase_90      <= config_reg[`ACMS_CFG_PHASE_BIT];
			o_output_swing_high <= config_reg[`ACMS_CFG_SWING_BIT];
			o_cal_delay_long    <= 1'b0;
			o_fscale_pin_high   <= 1'b0;
			o_fscale_from_regs  <= 1'b1;
			o_i_offset          <= i_off_reg;
			o_i_fscale          <= i_fs_reg;
			o_q_offset          <= q_off_reg;
			o_q_fscale          <= q_fs_reg;
			o_offset_enable     <= 1'b1;
			o_des_enable        <= de_en_reg[`ACMS_DE_ON_BIT];
			o_des_q_select      <= de_en_reg[`ACMS_DE_QSEL_BIT];
			o_des_auto_phase    <= de_en_reg[`ACMS_DE_AUTO_BIT];
			o_des_coarse        <= de_coarse_reg;
			o_des_fine          <= de_fine_reg;
		end else begin
			// Pin mode: registers ignored entirely
			o_ddr_enable        <= pin_float;
			o_sdr_rising_edge   <= pin_level;
			o_ddr_phase_90      <= 1'b0;
			o_output_swing_high <= swing_pin;
			o_cal_delay_long    <= cdelay_pin;
			o_fscale_pin_high   <= fs_pin;
			o_fscale_from_regs  <= 1'b0;
			o_i_offset          <= 16'h0000;
			o_i_fscale          <= 16'h0000;
			o_q_offset          <= 16'h0000;
			o_q_fscale          <= 16'h0000;
			o_offset_enable     <= 1'b0;
			o_des_enable        <= des_pin;
			o_des_q_select      <= 1'b0;
			o_des_auto_phase    <= 1'b1;
			o_des_coarse        <= 16'h0000;
			o_des_fine          <= 16'h0000;
		end
	end

endmodule

/* tb/acms_asserts.sv */
`timescale 1ns/100ps
module acms_asserts (
	input wire        i_clk_sys,
	input wire        i_rstn,
	input wire        i_control_mode_select,
	input wire        i_clk_pin_float,
	input wire        i_swing_pin,
	input wire        o_write_strobe,
	input wire        o_ddr_phase_90,
	input wire        o_ddr_enable,
	input wire        o_output_swing_high,
	input wire        o_cal_delay_long,
	input wire        o_offset_enable,
	input wire [15:0] o_i_offset,
	input wire [15:0] o_i_fscale
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// ==========================================================
	// Write pulse
	a_strobe_one_cycle: assert property (
		o_write_strobe |=> !o_write_strobe) else $error("long strobe");
	a_pin_no_write: assert property (
		!i_control_mode_select [*8] |-> !o_write_strobe)
		else $error("write in pin mode");
	// ==========================================================
	// Pin mode outputs; eight cycles cover the input sync delay
	a_pin_phase_zero: assert property (
		!i_control_mode_select [*8] |-> !o_ddr_phase_90)
		else $error("phase not zero in pin mode");
	a_pin_no_offset: assert property (
		!i_control_mode_select [*8] |-> o_i_offset == 16'h0000
		&& !o_offset_enable) else $error("offset in pin mode");
	a_pin_float_ddr: assert property (
		(!i_control_mode_select && i_clk_pin_float) [*8] |-> o_ddr_enable)
		else $error("floating pin not ddr");
	a_pin_swing: assert property (
		(!i_control_mode_select && $stable(i_swing_pin)) [*8]
		|-> o_output_swing_high == i_swing_pin) else $error("swing pin");
	// ==========================================================
	// Register mode
	a_reg_short_cal: assert property (
		i_control_mode_select [*8] |-> !o_cal_delay_long)
		else $error("long cal delay");
	a_reg_only_on_write: assert property (
		i_control_mode_select [*8] ##0
		(!o_write_strobe && !$past(o_write_strobe))
		|=> $stable(o_i_fscale)) else $error("register moved");
endmodule
bind acms_serial_config acms_asserts u_chk (.i_clk_sys, .i_rstn,
	.i_control_mode_select, .i_clk_pin_float, .i_swing_pin,
	.o_write_strobe, .o_ddr_phase_90, .o_ddr_enable,
	.o_output_swing_high, .o_cal_delay_long, .o_offset_enable,
	.o_i_offset, .o_i_fscale);

/* tb/acms_host_model.sv */
`timescale 1ns/100ps
module acms_host_model (
	output logic o_sclk,
	output logic o_sel_n,
	output logic o_serial_data_in
);
	// Idle: clock still low, select high, data line high
	initial begin
		o_sclk = 1'b0;
		o_sel_n = 1'b1;
		o_serial_data_in = 1'b1;
	end
	// ==========================================================
	// First n bits of a frame, MSB first, 48 ns serial period
	task automatic frame(input logic [11:0] h, input logic [3:0] a,
		input logic [15:0] d, input int n);
		logic [31:0] w;
		w = {h, a, d};
		o_sel_n = 1'b0;
		for (int k = 31; k > 31 - n; k--) begin
			o_serial_data_in = w[k];
			#24 o_sclk = 1'b1;
			#24 o_sclk = 1'b0;
		end
	endtask
	// Released data line shows the inverse of its last bit
	// Select stays high one serial period so the port sees the gap
	task automatic release_sel();
		#24 o_sel_n = 1'b1;
		o_serial_data_in = ~o_serial_data_in;
		#48;
	endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
	logic i_clk_sys, i_rstn, i_control_mode_select, i_clk_pin_float;
	logic i_clk_pin_level, i_swing_pin, i_cal_delay_pin, i_fscale_pin;
	logic i_des_pin;
	wire i_serial_clock, i_serial_select_n, i_serial_data_in;
	wire o_ddr_enable, o_sdr_rising_edge, o_ddr_phase_90;
	wire o_output_swing_high, o_cal_delay_long, o_fscale_pin_high;
	wire o_fscale_from_regs, o_offset_enable, o_des_enable;
	wire o_des_q_select, o_des_auto_phase, o_write_strobe;
	wire [15:0] o_i_offset, o_i_fscale, o_q_offset, o_q_fscale;
	wire [15:0] o_des_coarse, o_des_fine;
	logic [19:0] exp_q[$];
	logic [19:0] e;
	logic [15:0] r;
	logic [31:0] seed = 32'hfe9a_4ae8;
	logic [3:0] addrs[8] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
	logic [3:0] rsv[7] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc};
	int error_cnt, n_tests, cyc;
	acms_serial_config dut (.i_clk_sys, .i_rstn, .i_control_mode_select,
		.i_serial_clock, .i_serial_select_n, .i_serial_data_in,
		.i_clk_pin_float, .i_clk_pin_level, .i_swing_pin, .i_cal_delay_pin,
		.i_fscale_pin, .i_des_pin, .o_ddr_enable, .o_sdr_rising_edge,
		.o_ddr_phase_90, .o_output_swing_high, .o_cal_delay_long,
		.o_fscale_pin_high, .o_fscale_from_regs, .o_i_offset, .o_i_fscale,
		.o_q_offset, .o_q_fscale, .o_offset_enable, .o_des_enable,
		.o_des_q_select, .o_des_auto_phase, .o_des_coarse, .o_des_fine,
		.o_write_strobe);
	acms_host_model u_host (.o_sclk(i_serial_clock),
		.o_sel_n(i_serial_select_n), .o_serial_data_in(i_serial_data_in));
	// ==========================================================
	// Helpers
	function automatic logic [15:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[15:0];
	endfunction
	// Register view at the outputs; only decoded bits compared
	function automatic logic [15:0] got(input logic [3:0] a);
		case (a)
		4'h1: got = {4'h0, o_ddr_phase_90, ~o_ddr_enable,
			o_output_swing_high, o_sdr_rising_edge, 8'h00};
		4'h2: got = o_i_offset;
		4'h3: got = o_i_fscale;
		4'ha: got = o_q_offset;
		4'hb: got = o_q_fscale;
		4'hd: got = {o_des_enable, o_des_auto_phase, o_des_q_select, 13'h0};
		4'he: got = o_des_coarse;
		default: got = o_des_fine;
		endcase
	endfunction
	function automatic logic [15:0] msk(input logic [3:0] a);
		msk = (a == 4'h1) ? 16'h0f00 : (a == 4'hd) ? 16'he000 : 16'hffff;
	endfunction
	task automatic rst(input logic m);
		i_rstn <= 1'b0;
		i_control_mode_select <= m;
		repeat (5) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		repeat (8) @(posedge i_clk_sys);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		exp_q.push_back({a, d});
		u_host.frame(12'h001, a, d, 32);
	endtask
	// Bounded wait for queued writes, then any stray strobe shows
	task automatic drain(input string nm);
		for (int k = 0; k < 400 && exp_q.size() != 0; k++)
			@(posedge i_clk_sys);
		repeat (20) @(posedge i_clk_sys);
		`CHK("queue", 0, exp_q.size())
		$display("test %s done", nm);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================================
	// Clock, hang guard, strobe monitor
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end
	// Outputs land one cycle after the strobe
	initial forever begin
		@(negedge i_clk_sys);
		if (o_write_strobe === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("mismatch strobe exp 0 got 1");
			end else begin
				e = exp_q.pop_front();
				@(negedge i_clk_sys);
				`CHK("reg", e[15:0] & msk(e[19:16]), got(e[19:16]))
			end
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		{i_rstn, i_control_mode_select, i_clk_pin_float, i_clk_pin_level,
			i_swing_pin, i_cal_delay_pin, i_fscale_pin, i_des_pin} = '0;
		rst(1'b1);
		`CHK("ddr", 1'b1, o_ddr_enable)
		`CHK("ph90", 1'b0, o_ddr_phase_90)
		`CHK("swing", 1'b1, o_output_swing_high)
		`CHK("cal", 1'b0, o_cal_delay_long)
		`CHK("ifs", 16'h807f, o_i_fscale)
		`CHK("des", 1'b0, o_des_enable)
		$display("test defaults done");
		// All eight registers, select never released
		foreach (addrs[k]) wr(addrs[k], rnd());
		u_host.release_sel();
		drain("burst");
		// Wrong header, reserved places, cut frame
		u_host.frame(12'h003, 4'h2, 16'h1234, 32);
		foreach (rsv[k]) u_host.frame(12'h001, rsv[k], rnd(), 32);
		u_host.frame(12'h001, 4'h3, 16'h0f0f, 20);
		u_host.release_sel();
		wr(4'h3, rnd());
		u_host.release_sel();
		drain("faults");
		// Pin mode: port ignored, features follow pins
		for (int p = 0; p < 2; p++) begin
			r = rnd();
			{i_clk_pin_level, i_swing_pin, i_cal_delay_pin, i_fscale_pin} <= r[3:0];
			i_des_pin <= r[4];
			i_clk_pin_float <= (p == 0);
			rst(1'b0);
			u_host.frame(12'h001, 4'h2, 16'h5555, 32);
			u_host.release_sel();
			drain("pin");
			`CHK("ddr", i_clk_pin_float, o_ddr_enable)
			if (p == 1)
				`CHK("edge", i_clk_pin_level, o_sdr_rising_edge)
			`CHK("ph90", 1'b0, o_ddr_phase_90)
			`CHK("swing", i_swing_pin, o_output_swing_high)
			`CHK("cal", i_cal_delay_pin, o_cal_delay_long)
			`CHK("fsp", i_fscale_pin, o_fscale_pin_high)
			`CHK("fsr", 1'b0, o_fscale_from_regs)
			`CHK("ofs", 17'h0, {o_offset_enable, o_i_offset})
			`CHK("desq", 1'b0, o_des_q_select)
			`CHK("desa", 1'b1, o_des_auto_phase)
		end
		results();
	end
endmodule
